// ---- hw/lock_unit.sv ----
// One hardware lock with per-port take arbitration and holder record
`timescale 1ns/10ps
`default_nettype none
module lock_unit #(
   parameter int PORTS = mbox_pkg::PORT_COUNT
) (
   input  wire logic                        clk,          // System clock
   input  wire logic                        srst,         // Synchronous reset
   input  wire logic [PORTS-1:0]            take_req,     // Reads of the take bit
   input  wire logic                        release_req,  // Some port wrote 1
   output logic      [PORTS-1:0]            grant,        // Winner of this cycle
   output logic                             taken,        // Lock is held
   output logic      [mbox_pkg::HOLD_W-1:0] holder        // Holder code
);
   // ==========================================================
   // Arbitration
   // Lowest port index wins; only a free lock grants
   always_comb begin
      grant = '0;
      if (!taken) begin
         for (int p = PORTS - 1; p >= 0; p--) begin
            if (take_req[p]) begin
               grant = '0;
               grant[p] = 1'b1;
            end
         end
      end
   end
   // ==========================================================
   // Holder state
   // A release is honoured from any port, holder or not
   always_ff @(posedge clk) begin
      if (srst) begin
         taken  <= 1'b0;
         holder <= mbox_pkg::HOLD_FREE;
      end else if (taken) begin
         // Reads while held leave ownership alone
         if (release_req) begin
            taken  <= 1'b0;
            holder <= mbox_pkg::HOLD_FREE;
         end
      end else begin
         for (int p = 0; p < PORTS; p++) begin
            if (grant[p]) begin
               taken  <= 1'b1;
               // Code is port index plus one, zero stays free
               holder <= mbox_pkg::HOLD_W'(p + 1);
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- hw/mbox_lock_top.sv ----
// Mailbox word, two hardware locks and their software interrupts
//
// What this block does
// - One 32-bit mailbox word, read and writable
// - Clear mask clears only masked mailbox bits
// - Set mask sets only masked mailbox bits
// - Two fully independent locks
// - Reading free lock grants lowest-index reader, which reads 1
// - Reading held lock returns 0, ownership kept
// - Writing 1 to take bit frees lock
// - Any port may release a lock
// - Each access port is a distinct owner
// - Embedded cpu and PCIe share one owner
// - Holder field shows state and owning port
// - Lock state drives irq, polarity selectable
// - Lock 0 drives irq zero, 1 irq one
// - Manual trigger register raises either irq
// - Each irq routable to local or external
`timescale 1ns/10ps
`default_nettype none
module mbox_lock_top #(
   parameter int PORTS = mbox_pkg::PORT_COUNT,          // Access ports
   parameter int AW    = mbox_pkg::ADDR_W,              // Address width
   parameter int DW    = mbox_pkg::DATA_W               // Data width
) (
   input  wire logic                 CLK_SYS,           // 125 MHz clock
   input  wire logic                 SRST,              // Synchronous reset
   input  wire logic [PORTS-1:0]     REQ_VALID,         // Request per port
   input  wire logic [PORTS-1:0]     REQ_WRITE,         // 1 write, 0 read
   input  wire logic [PORTS*AW-1:0]  REQ_ADDR,          // Byte offsets, packed
   input  wire logic [PORTS*DW-1:0]  REQ_WDATA,         // Write data, packed
   output logic      [PORTS-1:0]     RESP_VALID,        // Answer pulse
   output logic      [PORTS*DW-1:0]  RESP_RDATA,        // Read data, packed
   output logic                      SOFT_IRQ_ZERO_CPU, // Irq zero, local cpu
   output logic                      SOFT_IRQ_ONE_CPU,  // Irq one, local cpu
   output logic                      SOFT_IRQ_ZERO_EXT, // Irq zero, external
   output logic                      SOFT_IRQ_ONE_EXT   // Irq one, external
);
   // Port 0 is the switch-core access path, which carries both the
   // embedded cpu and the PCIe endpoint, so the two share one owner.
   // Ports 1..3 are the parallel, serial and management serial ports.

   // ==========================================================
   // Helpers
   // Slice one port's address out of the packed bus
   function automatic logic [AW-1:0] addr_of(input logic [PORTS*AW-1:0] bus,
                                             input int p);
      addr_of = bus[p*AW +: AW];
   endfunction

   // Slice one port's write word out of the packed bus
   function automatic logic [DW-1:0] wdata_of(input logic [PORTS*DW-1:0] bus,
                                              input int p);
      wdata_of = bus[p*DW +: DW];
   endfunction

   // Interrupt level: polarity 1 flags held, polarity 0 flags free
   function automatic logic irq_level(input logic held, input logic pol,
                                      input logic force_it);
      irq_level = force_it | (held == pol);
   endfunction

   // ==========================================================
   // Register state
   logic [DW-1:0]               mailbox;                 // Shared word
   logic [DW-1:0]               next_mailbox;            // Word after writes
   logic [1:0]                  lock_irq_polarity;       // Per-lock polarity
   logic [1:0]                  irq_manual_trigger;      // Forced irq bits
   logic [1:0]                  irq_route;               // 1 = external out
   logic [PORTS-1:0]            take_zero_rd;            // Reads of lock 0
   logic [PORTS-1:0]            take_one_rd;             // Reads of lock 1
   logic                        release_zero;            // Release of lock 0
   logic                        release_one;             // Release of lock 1
   logic [PORTS-1:0]            grant_zero;              // Lock 0 winner
   logic [PORTS-1:0]            grant_one;               // Lock 1 winner
   logic                        taken_zero;              // Lock 0 held
   logic                        taken_one;               // Lock 1 held
   logic [mbox_pkg::HOLD_W-1:0] lock_zero_holder;        // Lock 0 holder
   logic [mbox_pkg::HOLD_W-1:0] lock_one_holder;         // Lock 1 holder

   // ==========================================================
   // Request decode for the locks
   // Take reads and releases, collected from every port
   always_comb begin
      take_zero_rd = '0;
      take_one_rd  = '0;
      release_zero = 1'b0;
      release_one  = 1'b0;
      for (int p = 0; p < PORTS; p++) begin
         if (REQ_VALID[p] && !REQ_WRITE[p]) begin
            // A read of a take bit is an attempt to take
            if (addr_of(REQ_ADDR, p) == mbox_pkg::OFS_TAKE_ZERO) begin
               take_zero_rd[p] = 1'b1;
            end
            if (addr_of(REQ_ADDR, p) == mbox_pkg::OFS_TAKE_ONE) begin
               take_one_rd[p] = 1'b1;
            end
         end
         if (REQ_VALID[p] && REQ_WRITE[p] &&
             REQ_WDATA[p*DW + mbox_pkg::TAKE_BIT]) begin
            // Writing 1 releases, from whichever port it comes
            if (addr_of(REQ_ADDR, p) == mbox_pkg::OFS_TAKE_ZERO) begin
               release_zero = 1'b1;
            end
            if (addr_of(REQ_ADDR, p) == mbox_pkg::OFS_TAKE_ONE) begin
               release_one = 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // The two locks
   // Separate instances so one never affects the other
   lock_unit #(
      .PORTS       (PORTS)
   ) u_lock_zero (
      .clk         (CLK_SYS),
      .srst        (SRST),
      .take_req    (take_zero_rd),
      .release_req (release_zero),
      .grant       (grant_zero),
      .taken       (taken_zero),
      .holder      (lock_zero_holder)
   );

   lock_unit #(
      .PORTS       (PORTS)
   ) u_lock_one (
      .clk         (CLK_SYS),
      .srst        (SRST),
      .take_req    (take_one_rd),
      .release_req (release_one),
      .grant       (grant_one),
      .taken       (taken_one),
      .holder      (lock_one_holder)
   );

   // ==========================================================
   // Mailbox update
   // Writes are applied in port order so that several writes in one
   // cycle compose exactly as if they were sequential; the highest
   // port index is applied last and so has the final word.
   always_comb begin
      next_mailbox = mailbox;
      for (int p = 0; p < PORTS; p++) begin
         if (REQ_VALID[p] && REQ_WRITE[p]) begin
            unique case (addr_of(REQ_ADDR, p))
               mbox_pkg::OFS_MSG_VALUE: begin
                  // Plain overwrite
                  next_mailbox = wdata_of(REQ_WDATA, p);
               end
               mbox_pkg::OFS_MSG_SET: begin
                  // Only masked bits go high
                  next_mailbox = next_mailbox | wdata_of(REQ_WDATA, p);
               end
               mbox_pkg::OFS_MSG_CLEAR: begin
                  // Only masked bits go low
                  next_mailbox = next_mailbox & ~wdata_of(REQ_WDATA, p);
               end
               default: begin
                  // Other offsets leave the word alone
                  next_mailbox = next_mailbox;
               end
            endcase
         end
      end
   end

   // Mailbox register, one-cycle atomic read-modify-write
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         mailbox <= mbox_pkg::MSG_RESET;
      end else begin
         mailbox <= next_mailbox;
      end
   end

   // ==========================================================
   // Interrupt configuration registers
   // Polarity, manual trigger and routing; last writing port wins
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         lock_irq_polarity  <= mbox_pkg::POL_RESET;
         irq_manual_trigger <= mbox_pkg::FORCE_RESET;
         irq_route          <= mbox_pkg::ROUTE_RESET;
      end else begin
         for (int p = 0; p < PORTS; p++) begin
            if (REQ_VALID[p] && REQ_WRITE[p]) begin
               if (addr_of(REQ_ADDR, p) == mbox_pkg::OFS_IRQ_CONFIG) begin
                  lock_irq_polarity <= REQ_WDATA[p*DW +: 2];
               end
               if (addr_of(REQ_ADDR, p) == mbox_pkg::OFS_IRQ_FORCE) begin
                  irq_manual_trigger <= REQ_WDATA[p*DW +: 2];
               end
               if (addr_of(REQ_ADDR, p) == mbox_pkg::OFS_IRQ_ROUTE) begin
                  irq_route <= REQ_WDATA[p*DW +: 2];
               end
            end
         end
      end
   end

   // ==========================================================
   // Read answers
   // Every request, read or write, is answered one cycle later.
   // Reads see the state before this cycle's writes take effect.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         RESP_VALID <= '0;
         RESP_RDATA <= '0;
      end else begin
         RESP_VALID <= REQ_VALID;
         for (int p = 0; p < PORTS; p++) begin
            RESP_RDATA[p*DW +: DW] <= mbox_pkg::READ_ZERO;
            if (REQ_VALID[p] && !REQ_WRITE[p]) begin
               unique case (addr_of(REQ_ADDR, p))
                  mbox_pkg::OFS_MSG_VALUE: begin
                     RESP_RDATA[p*DW +: DW] <= mailbox;
                  end
                  mbox_pkg::OFS_IRQ_CONFIG: begin
                     RESP_RDATA[p*DW +: 2] <= lock_irq_polarity;
                  end
                  mbox_pkg::OFS_TAKE_ZERO: begin
                     // 1 only for the single winner of a free lock
                     RESP_RDATA[p*DW + mbox_pkg::TAKE_BIT] <= grant_zero[p];
                  end
                  mbox_pkg::OFS_TAKE_ONE: begin
                     RESP_RDATA[p*DW + mbox_pkg::TAKE_BIT] <= grant_one[p];
                  end
                  mbox_pkg::OFS_HOLD_ZERO: begin
                     // Zero means free, else port index plus one
                     RESP_RDATA[p*DW +: mbox_pkg::HOLD_W] <= lock_zero_holder;
                  end
                  mbox_pkg::OFS_HOLD_ONE: begin
                     RESP_RDATA[p*DW +: mbox_pkg::HOLD_W] <= lock_one_holder;
                  end
                  mbox_pkg::OFS_IRQ_FORCE: begin
                     RESP_RDATA[p*DW +: 2] <= irq_manual_trigger;
                  end
                  mbox_pkg::OFS_IRQ_ROUTE: begin
                     RESP_RDATA[p*DW +: 2] <= irq_route;
                  end
                  default: begin
                     // Set and clear masks and holes read as zero
                     RESP_RDATA[p*DW +: DW] <= mbox_pkg::READ_ZERO;
                  end
               endcase
            end
         end
      end
   end

   // ==========================================================
   // Software interrupt outputs
   // Levels, registered so each pin is glitch free. The output not
   // selected by the route bit is held low rather than mirrored.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         SOFT_IRQ_ZERO_CPU <= 1'b0;
         SOFT_IRQ_ONE_CPU  <= 1'b0;
         SOFT_IRQ_ZERO_EXT <= 1'b0;
         SOFT_IRQ_ONE_EXT  <= 1'b0;
      end else begin
         // Lock 0 feeds irq zero
         SOFT_IRQ_ZERO_CPU <= !irq_route[0] &&
            irq_level(taken_zero, lock_irq_polarity[0],
                      irq_manual_trigger[0]);
         SOFT_IRQ_ZERO_EXT <= irq_route[0] &&
            irq_level(taken_zero, lock_irq_polarity[0],
                      irq_manual_trigger[0]);
         // Lock 1 feeds irq one
         SOFT_IRQ_ONE_CPU <= !irq_route[1] &&
            irq_level(taken_one, lock_irq_polarity[1],
                      irq_manual_trigger[1]);
         SOFT_IRQ_ONE_EXT <= irq_route[1] &&
            irq_level(taken_one, lock_irq_polarity[1],
                      irq_manual_trigger[1]);
      end
   end
endmodule
`default_nettype wire

// ---- inc/mbox_pkg.sv ----
// Shared constants for the mailbox and hardware lock block
package mbox_pkg;
   // ==========================================================
   // Bus geometry
   localparam int ADDR_W     = 8;          // Byte-offset bits per port
   localparam int DATA_W     = 32;         // Register data width
   localparam int PORT_COUNT = 4;          // Access ports that may own a lock
   localparam int LOCK_COUNT = 2;          // Independent hardware locks
   // ==========================================================
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_MSG_VALUE  = 8'h00; // Mailbox word
   localparam logic [ADDR_W-1:0] OFS_MSG_SET    = 8'h04; // Mailbox set mask
   localparam logic [ADDR_W-1:0] OFS_MSG_CLEAR  = 8'h08; // Mailbox clear mask
   localparam logic [ADDR_W-1:0] OFS_IRQ_CONFIG = 8'h0c; // Interrupt polarity
   localparam logic [ADDR_W-1:0] OFS_TAKE_ZERO  = 8'h10; // Lock 0 take bit
   localparam logic [ADDR_W-1:0] OFS_TAKE_ONE   = 8'h14; // Lock 1 take bit
   localparam logic [ADDR_W-1:0] OFS_HOLD_ZERO  = 8'h18; // Lock 0 holder
   localparam logic [ADDR_W-1:0] OFS_HOLD_ONE   = 8'h1c; // Lock 1 holder
   localparam logic [ADDR_W-1:0] OFS_IRQ_FORCE  = 8'h20; // Manual trigger
   localparam logic [ADDR_W-1:0] OFS_IRQ_ROUTE  = 8'h24; // Interrupt routing
   // ==========================================================
   // Field positions and reset values
   localparam int                TAKE_BIT      = 0;        // Take / release bit
   localparam logic [DATA_W-1:0] MSG_RESET     = 32'h0;    // Mailbox at reset
   localparam logic [1:0]        POL_RESET     = 2'h0;     // Polarity at reset
   localparam logic [1:0]        FORCE_RESET   = 2'h0;     // No forced irq
   localparam logic [1:0]        ROUTE_RESET   = 2'h0;     // All to local cpu
   localparam logic [DATA_W-1:0] READ_ZERO     = 32'h0;    // Unmapped reads
   // ==========================================================
   // Holder code for a free lock
   localparam int HOLD_W = 3;                              // Fits ports plus free
   localparam logic [HOLD_W-1:0] HOLD_FREE = 3'h0;         // Nobody holds it
endpackage

// ---- tb/mbox_lock_top_monitor.sv ----
// Checker for the mailbox and lock block ports
`timescale 1ns/10ps
`default_nettype none
module mbox_lock_top_monitor #(
   parameter int PORTS = 4,
   parameter int AW    = 8,
   parameter int DW    = 32
) (
   input wire logic                 CLK_SYS,
   input wire logic                 SRST,
   input wire logic [PORTS-1:0]     REQ_VALID,
   input wire logic [PORTS-1:0]     REQ_WRITE,
   input wire logic [PORTS*AW-1:0]  REQ_ADDR,
   input wire logic [PORTS*DW-1:0]  REQ_WDATA,
   input wire logic [PORTS-1:0]     RESP_VALID,
   input wire logic [PORTS*DW-1:0]  RESP_RDATA,
   input wire logic                 SOFT_IRQ_ZERO_CPU,
   input wire logic                 SOFT_IRQ_ONE_CPU,
   input wire logic                 SOFT_IRQ_ZERO_EXT,
   input wire logic                 SOFT_IRQ_ONE_EXT
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SRST);
   // ==================
   // Shadow of lock zero; a release only frees a held lock, a take only grabs a free one
   logic [PORTS-1:0]  take0;  // Reads of the lock zero take bit
   logic [PORTS-1:0]  rel0;   // Writes of 1 to it
   logic              held0;  // Lock zero is taken
   always_comb begin
      for (int p = 0; p < PORTS; p++) begin
         take0[p] = REQ_VALID[p] && !REQ_WRITE[p] && REQ_ADDR[p*AW+:AW] == mbox_pkg::OFS_TAKE_ZERO;
         rel0[p]  = REQ_VALID[p] && REQ_WRITE[p] && REQ_ADDR[p*AW+:AW] == mbox_pkg::OFS_TAKE_ZERO
                    && REQ_WDATA[p*DW];
      end
   end
   // Shadow update follows the pre-state semantics of the answers
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         held0 <= 1'b0;
      end else if (held0) begin
         if (|rel0) begin
            held0 <= 1'b0;
         end
      end else if (|take0) begin
         held0 <= 1'b1;
      end
   end
   // ==================
   // Assertions
   a_resp_follows_req: assert property (1'b1 |=> RESP_VALID == $past(REQ_VALID))
      else $error("answer pulse does not follow request");
   a_idle_data_zero: assert property (!RESP_VALID[0] |-> RESP_RDATA[DW-1:0] == 32'h0)
      else $error("read data not zero without answer");
   a_free_take_one: assert property (take0[0] && !held0 |=> RESP_RDATA[DW-1:0] == 32'h1)
      else $error("take of free lock did not return 1");
   a_held_take_zero: assert property (take0[1] && held0 |=> RESP_RDATA[DW+:DW] == 32'h0)
      else $error("take of held lock did not return 0");
   a_tie_low_wins: assert property (take0[0] && take0[1] && !held0 |=> RESP_RDATA[DW] == 1'b0)
      else $error("two ports both won one lock");
   a_free_holder_zero: assert property (REQ_VALID[2] && !REQ_WRITE[2] && !held0
      && REQ_ADDR[2*AW+:AW] == mbox_pkg::OFS_HOLD_ZERO |=> RESP_RDATA[2*DW+:DW] == 32'h0)
      else $error("free lock shows a holder");
   a_held_holder_code: assert property (REQ_VALID[2] && !REQ_WRITE[2] && held0
      && REQ_ADDR[2*AW+:AW] == mbox_pkg::OFS_HOLD_ZERO |=> RESP_RDATA[2*DW+:DW] inside {[1:4]})
      else $error("held lock shows no valid holder");
   a_zero_one_route: assert property (!(SOFT_IRQ_ZERO_CPU && SOFT_IRQ_ZERO_EXT))
      else $error("irq zero on both outputs");
   a_one_one_route: assert property (!(SOFT_IRQ_ONE_CPU && SOFT_IRQ_ONE_EXT))
      else $error("irq one on both outputs");
endmodule
bind mbox_lock_top mbox_lock_top_monitor #(.PORTS(PORTS), .AW(AW), .DW(DW)) u_mon (.*);
`default_nettype wire

// ---- tb/mbox_port_model.sv ----
// Model of the CPU access ports that face the mailbox and lock block
`timescale 1ns/10ps
`default_nettype none
module mbox_port_model (
   input  wire logic          clk,         // System clock
   output var  logic [3:0]    req_valid,   // Request per port
   output var  logic [3:0]    req_write,   // 1 write, 0 read
   output var  logic [31:0]   req_addr,    // Byte offsets, packed
   output var  logic [127:0]  req_wdata,   // Write data, packed
   input  wire logic [3:0]    resp_valid,  // Answer pulse
   input  wire logic [127:0]  resp_rdata   // Read data, packed
);
   // ==================
   // Idle values at time zero
   initial begin
      req_valid = 4'h0;
      req_write = 4'h0;
      req_addr  = 32'h0;
      req_wdata = 128'h0;
   end
   // ==================
   // One access cycle on any set of ports; a release is a write of 1
   // Idle lines get the inverse so stale values can never pass for a match
   task automatic xfer(input logic [3:0] v, input logic [3:0] w, input logic [31:0] a,
                       input logic [127:0] d, output logic [127:0] rd, output logic [3:0] rv);
      @(posedge clk);
      #1;
      req_valid = v;
      req_write = w;
      req_addr  = a;
      req_wdata = d;
      @(posedge clk);
      #1;
      rv = resp_valid;
      rd = resp_rdata;
      req_valid = 4'h0;
      req_write = ~w;
      req_addr  = ~a;
      req_wdata = ~d;
   endtask
endmodule
`default_nettype wire

// ---- tb/test_mbox_lock_top.sv ----
// Self-checking testbench for the mailbox and lock block
`timescale 1ns/10ps
`default_nettype none
module test_mbox_lock_top;
   logic          clk_sys = 1'b0;  // 125 MHz clock
   logic          srst = 1'b1;     // Held for four cycles
   logic [3:0]    req_valid;       // Port requests
   logic [3:0]    req_write;
   logic [31:0]   req_addr;
   logic [127:0]  req_wdata;
   logic [3:0]    resp_valid;      // Port answers
   logic [127:0]  resp_rdata;
   logic [3:0]    irq;             // {one ext, zero ext, one cpu, zero cpu}
   int            num_errors = 0;
   int            n_compared = 0;
   always #4 clk_sys = ~clk_sys;
   mbox_port_model mdl (.clk(clk_sys), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .resp_valid(resp_valid), .resp_rdata(resp_rdata));
   mbox_lock_top dut (.CLK_SYS(clk_sys), .SRST(srst), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
      .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .RESP_VALID(resp_valid), .RESP_RDATA(resp_rdata),
      .SOFT_IRQ_ZERO_CPU(irq[0]), .SOFT_IRQ_ONE_CPU(irq[1]), .SOFT_IRQ_ZERO_EXT(irq[2]),
      .SOFT_IRQ_ONE_EXT(irq[3]));
   // ==================
   // Compare tasks, one per kind of result
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("wrong value at %0t: word %h expected %h", $time, got, exp);
         num_errors++;
      end
   endtask
   // Irq levels lag the state by a cycle, so let one edge pass first
   task automatic cmp_irq(input logic [3:0] exp);
      @(posedge clk_sys);
      #1;
      n_compared++;
      if (irq !== exp) begin
         $display("wrong value at %0t: irq %b expected %b", $time, irq, exp);
         num_errors++;
      end
   endtask
   // ==================
   // Single-port access; every access must be answered
   task automatic acc(input int p, input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] exp);
      logic [127:0] rd;
      logic [3:0]   rv;
      mdl.xfer(4'h1 << p, {4{w}}, {4{a}}, {4{d}}, rd, rv);
      cmp_word({31'h0, rv[p]}, 32'h1);
      if (!w) cmp_word(rd[p*32+:32], exp);
   endtask
   task automatic wr(input int p, input logic [7:0] a, input logic [31:0] d);
      acc(p, 1'b1, a, d, 32'h0);
   endtask
   task automatic rd(input int p, input logic [7:0] a, input logic [31:0] exp);
      acc(p, 1'b0, a, 32'h0, exp);
   endtask
   // ==================
   // Verdict
   task automatic tally_and_finish;
      if (num_errors == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Watchdog at 5000 cycles, far beyond the roughly 71 cycles the tests need
   initial begin
      #(5000 * 8);
      num_errors++;
      tally_and_finish();
   end
   // ==================
   // Main sequence
   initial begin
      logic [127:0] both;
      logic [3:0]   rv;
      repeat (4) @(posedge clk_sys);
      #1;
      srst = 1'b0;
      rd(0, 8'h00, 32'h0);
      wr(1, 8'h00, 32'ha5a5_0f0f);
      rd(2, 8'h00, 32'ha5a5_0f0f);
      wr(3, 8'h04, 32'h0000_f0f0);
      rd(0, 8'h00, 32'ha5a5_ffff);
      wr(2, 8'h08, 32'ha5a5_0000);
      rd(1, 8'h00, 32'h0000_ffff);
      rd(0, 8'h04, 32'h0);
      rd(2, 8'h18, 32'h0);
      cmp_irq(4'h3);
      rd(1, 8'h10, 32'h1);
      rd(1, 8'h10, 32'h0);
      rd(2, 8'h10, 32'h0);
      rd(2, 8'h18, 32'h2);
      rd(0, 8'h1c, 32'h0);
      cmp_irq(4'h2);
      rd(3, 8'h14, 32'h1);
      rd(2, 8'h1c, 32'h4);
      cmp_irq(4'h0);
      wr(0, 8'h10, 32'h1);
      rd(2, 8'h18, 32'h0);
      wr(3, 8'h14, 32'h1);
      cmp_irq(4'h3);
      mdl.xfer(4'h3, 4'h0, {4{8'h10}}, 128'h0, both, rv);
      cmp_word(both[31:0], 32'h1);
      cmp_word(both[63:32], 32'h0);
      rd(2, 8'h18, 32'h1);
      wr(2, 8'h10, 32'h1);
      wr(1, 8'h0c, 32'h3);
      cmp_irq(4'h0);
      rd(0, 8'h14, 32'h1);
      cmp_irq(4'h2);
      wr(0, 8'h20, 32'h1);
      cmp_irq(4'h3);
      wr(3, 8'h24, 32'h1);
      cmp_irq(4'h6);
      wr(0, 8'h20, 32'h0);
      cmp_irq(4'h2);
      wr(3, 8'h24, 32'h3);
      cmp_irq(4'h8);
      rd(2, 8'h40, 32'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
